// file: logic/dos_defs.svh
// constants of the drive overshoot and shutdown block
`ifndef DOS_DEFS_SVH
`define DOS_DEFS_SVH
`define DOS_OFF_SETPOINT 8'h00
`define DOS_OFF_CTRL     8'h04
`define DOS_OFF_DRIVE    8'h08
`define DOS_OFF_STATUS   8'h0c
`define DOS_OFF_FAULT    8'h10
`define DOS_OFF_TEMPCMD  8'h14
`define DOS_OFF_IND      8'h18
`define DOS_CTRL_LIMIT   0
`define DOS_CTRL_MANUAL  1
`define DOS_CTRL_REQACK  2
`define DOS_FAULT_DRIVE  9
`define DOS_DRV_MASK     16'h0fff
`define DOS_STOP_WORD    16'hc000
`define DOS_IND_MASK     16'hff97
`define DOS_EOI_TIMER    16'h0008
`define DOS_EOI_PRIO     16'h0003
`define DOS_STEP         12'h004
`define DOS_CONV_LIMIT   16'h0004
`define DOS_PRESCALE     20
`define DOS_CLK_HZ       250000000
`define DOS_TICK_HZ      1800
`define DOS_TICK_CYCLES  (`DOS_CLK_HZ / `DOS_TICK_HZ)
`endif

// file: logic/dos_pkg.sv
// types of the drive overshoot and shutdown block
package dos_pkg;
  // tick sequencer, one-hot
  typedef enum logic [5:0] {
    SQ_WAIT   = 6'b000001,
    SQ_STOP   = 6'b000010,
    SQ_EOI    = 6'b000100,
    SQ_BRAKE  = 6'b001000,
    SQ_EXIT_A = 6'b010000,
    SQ_EXIT_B = 6'b100000
  } dos_seq_t;
  // drive regime, one-hot
  typedef enum logic [3:0] {
    RG_IDLE  = 4'b0001,
    RG_CREEP = 4'b0010,
    RG_OVR   = 4'b0100,
    RG_DOWN  = 4'b1000
  } dos_regime_t;
  // ahb-lite request from the master
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } dos_ahb_req_t;
  // ahb-lite answer of the slave
  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } dos_ahb_rsp_t;
  // end-of-interrupt write toward the interrupt controller
  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } dos_eoi_t;
endpackage

// file: logic/dos_drive_ctrl.sv
// drive overshoot handling, ramp-down and stopped shutdown, ahb-lite slave
`timescale 1ns/1ps
`include "dos_defs.svh"

module dos_drive_ctrl
#(
  parameter int unsigned TICK_CYCLES = `DOS_TICK_CYCLES,
  parameter int unsigned PRESCALE    = `DOS_PRESCALE
)
(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire dos_pkg::dos_ahb_req_t ahb_req,
  output      dos_pkg::dos_ahb_rsp_t ahb_rsp,
  input  wire logic signed [15:0]  pos_error,
  input  wire logic                error_dir,
  input  wire logic                estop_pin,
  input  wire logic                lockout_pin,
  output      logic [15:0]         drive_word,
  output      logic                dac_latch,
  output      dos_pkg::dos_eoi_t   end_of_interrupt_register,
  output      logic                brake_release,
  output      logic                timer_stop,
  output      logic [15:0]         indicator
);
  import dos_pkg::*;

  localparam int CW = $clog2(TICK_CYCLES);

  // step a 12-bit signed drive 4 counts, down if pos_dir else up; zero stays zero
  function automatic logic [11:0] step_zero(input logic [11:0] val,
                                            input logic        pos_dir);
    logic [11:0] res;
    res = val;
    if (val != 12'h000)
      res = pos_dir ? val - `DOS_STEP : val + `DOS_STEP;
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  dos_seq_t    seq_reg, seq_next;          // tick sequencer
  dos_regime_t regime_reg, regime_next;    // drive regime
  logic [15:0] word_reg, word_next;        // drive value plus discretes
  logic [4:0]  presc_reg, presc_next;      // ramp-down rate prescaler
  logic        latch_reg, latch_next;      // d/a latch strobe
  logic        eoi_wr_reg, eoi_wr_next;    // eoi write strobe
  logic [15:0] eoi_data_reg, eoi_data_next;
  logic        brake_reg, brake_next;      // brake release strobe
  logic        tstop_reg, tstop_next;      // timer stop strobe
  logic [CW-1:0] tick_cnt_reg;             // tick divider
  logic        timers_on_reg;              // drive timers running
  logic        tick;                       // one-cycle tick pulse
  logic        init_dir_reg;               // direction at command start
  logic        retry_used_flag;
  logic        drive_active_flag;
  logic        drive_request_flag;
  logic        shutdown_request_flag;
  logic [15:0] fault_word;
  logic [15:0] commanded_setpoint;
  logic [15:0] temp_command;
  logic [15:0] ind_reg;                    // indicator bits
  // event strobes from the sequencer
  logic        ev_fault, ev_request, ev_stop_clear;
  // pin synchronisers
  logic [1:0]  estop_sync, lock_sync;
  logic        halt_now;
  // bus
  logic        wr_pend_reg;
  logic [7:0]  addr_reg;
  logic [31:0] rdata_reg;
  logic        addr_phase;
  logic        wr_setpoint, wr_ctrl, wr_drive, wr_fault, wr_ind;
  // datapath helpers
  logic [11:0] drive_mag;
  logic [15:0] discretes;
  logic [11:0] stepped;
  logic        err_small;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay

  assign addr_phase = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;
  assign wr_setpoint = wr_pend_reg & (addr_reg == `DOS_OFF_SETPOINT);
  assign wr_ctrl     = wr_pend_reg & (addr_reg == `DOS_OFF_CTRL);
  assign wr_drive    = wr_pend_reg & (addr_reg == `DOS_OFF_DRIVE);
  assign wr_fault    = wr_pend_reg & (addr_reg == `DOS_OFF_FAULT);
  assign wr_ind      = wr_pend_reg & (addr_reg == `DOS_OFF_IND);

  // address phase capture and read data register
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
      rdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= addr_phase & ahb_req.hwrite;
      if (addr_phase)
        addr_reg <= {ahb_req.haddr[7:2], 2'b00};
      rdata_reg <= 32'h0000_0000;
      if (addr_phase & ~ahb_req.hwrite)
      begin
        unique case ({ahb_req.haddr[7:2], 2'b00})
          `DOS_OFF_SETPOINT: rdata_reg <= {16'h0000, commanded_setpoint};
          `DOS_OFF_DRIVE:    rdata_reg <= {16'h0000, word_reg};
          `DOS_OFF_STATUS:   rdata_reg <= {16'h0000, seq_reg, regime_reg,
                                           timers_on_reg, init_dir_reg,
                                           retry_used_flag, drive_active_flag,
                                           drive_request_flag,
                                           shutdown_request_flag};
          `DOS_OFF_FAULT:    rdata_reg <= {16'h0000, fault_word};
          `DOS_OFF_TEMPCMD:  rdata_reg <= {16'h0000, temp_command};
          `DOS_OFF_IND:      rdata_reg <= {16'h0000, ind_reg};
          default:           rdata_reg <= 32'h0000_0000; // unmapped reads zero
        endcase
      end
    end
  end

  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp     = 1'b0;
  assign ahb_rsp.hrdata    = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, first stage read only by the second

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      estop_sync <= 2'b00;
      lock_sync  <= 2'b00;
    end
    else
    begin
      estop_sync <= {estop_sync[0], estop_pin};
      lock_sync  <= {lock_sync[0], lockout_pin};
    end
  end

  assign halt_now = estop_sync[1] | lock_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // 1800 hz tick, runs only while the drive timers are on

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      tick_cnt_reg  <= '0;
      timers_on_reg <= 1'b0;
    end
    else
    begin
      if (tstop_reg)
        timers_on_reg <= 1'b0;
      else if (wr_drive)
        timers_on_reg <= 1'b1;
      if (!timers_on_reg || tick)
        tick_cnt_reg <= CW'(TICK_CYCLES - 1);
      else
        tick_cnt_reg <= tick_cnt_reg - 1'b1;
    end
  end

  assign tick = timers_on_reg && (tick_cnt_reg == '0);

  ////////////////////////////////////////////////////////////////////////////
  // tick decision

  // discretes stripped before any arithmetic on the drive value
  assign drive_mag = 12'(word_reg & `DOS_DRV_MASK);
  assign discretes = word_reg & ~`DOS_DRV_MASK;
  assign stepped   = step_zero(drive_mag, init_dir_reg);
  assign err_small = (pos_error < $signed(`DOS_CONV_LIMIT)) &&
                     (pos_error > -$signed(`DOS_CONV_LIMIT));

  always_comb
  begin
    seq_next      = seq_reg;
    regime_next   = regime_reg;
    word_next     = word_reg;
    presc_next    = presc_reg;
    latch_next    = 1'b0;
    eoi_wr_next   = 1'b0;
    eoi_data_next = eoi_data_reg;
    brake_next    = 1'b0;
    tstop_next    = 1'b0;
    ev_fault      = 1'b0;
    ev_request    = 1'b0;
    ev_stop_clear = 1'b0;
    unique case (seq_reg)
      SQ_WAIT:
      begin
        // a drive write starts creep; it outranks a tick in the same cycle
        if (wr_drive)
        begin
          word_next   = ahb_req.hwdata[15:0];
          latch_next  = 1'b1;
          regime_next = RG_CREEP;
          presc_next  = 5'(PRESCALE);
        end
        else if (tick && regime_reg != RG_IDLE)
        begin
          seq_next = SQ_EXIT_A;
          if (halt_now)
            seq_next = SQ_STOP;
          else if (shutdown_request_flag || regime_reg == RG_DOWN)
          begin
            regime_next = RG_DOWN;
            presc_next  = presc_reg - 5'd1;
            if (presc_reg == 5'd1)
            begin
              presc_next = 5'(PRESCALE);
              word_next  = discretes | {4'h0, stepped};
              latch_next = 1'b1;
              if (stepped == 12'h000)
                seq_next = SQ_STOP;
            end
            else if (drive_mag == 12'h000)
              seq_next = SQ_STOP;
          end
          else if (regime_reg == RG_CREEP && err_small)
            regime_next = RG_DOWN;
          else if (regime_reg == RG_CREEP && error_dir == init_dir_reg)
            latch_next = 1'b1;
          else
          begin
            // overshoot seen now, or ramp already under way
            regime_next = RG_OVR;
            word_next   = discretes | {4'h0, stepped};
            latch_next  = 1'b1;
            if (stepped == 12'h000)
            begin
              seq_next = SQ_STOP;
              if (retry_used_flag)
                ev_fault = 1'b1;
              else
                ev_request = 1'b1;
            end                                              // else
          end
        end
      end
      SQ_STOP:
      begin
        tstop_next  = 1'b1;
        word_next   = `DOS_STOP_WORD;
        latch_next  = 1'b1;
        seq_next    = SQ_EOI;
      end
      SQ_EOI:
      begin
        eoi_wr_next   = 1'b1;
        eoi_data_next = `DOS_EOI_TIMER;
        seq_next      = SQ_BRAKE;
      end
      SQ_BRAKE:
      begin
        brake_next    = 1'b1;
        ev_stop_clear = 1'b1;
        regime_next   = RG_IDLE;
        seq_next      = SQ_EXIT_A;
      end
      SQ_EXIT_A:
      begin
        eoi_wr_next   = 1'b1;
        eoi_data_next = `DOS_EOI_TIMER;
        seq_next      = SQ_EXIT_B;
      end
      SQ_EXIT_B:
      begin
        eoi_wr_next   = 1'b1;
        eoi_data_next = `DOS_EOI_PRIO;
        seq_next      = SQ_WAIT;
      end
      default:
        seq_next = SQ_WAIT;                                  // illegal code
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and drive datapath registers

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      seq_reg      <= SQ_WAIT;
      regime_reg   <= RG_IDLE;
      word_reg     <= 16'h0000;
      presc_reg    <= 5'd0;
      latch_reg    <= 1'b0;
      eoi_wr_reg   <= 1'b0;
      eoi_data_reg <= 16'h0000;
      brake_reg    <= 1'b0;
      tstop_reg    <= 1'b0;
      init_dir_reg <= 1'b0;
    end
    else
    begin
      seq_reg      <= seq_next;
      regime_reg   <= regime_next;
      word_reg     <= word_next;
      presc_reg    <= presc_next;
      latch_reg    <= latch_next;
      eoi_wr_reg   <= eoi_wr_next;
      eoi_data_reg <= eoi_data_next;
      brake_reg    <= brake_next;
      tstop_reg    <= tstop_next;
      // direction recorded as the command begins
      if (seq_reg == SQ_WAIT && wr_drive)
        init_dir_reg <= error_dir;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags; hardware set wins over a clear in the same cycle

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      retry_used_flag       <= 1'b0;
      drive_active_flag     <= 1'b0;
      drive_request_flag    <= 1'b0;
      shutdown_request_flag <= 1'b0;
      fault_word            <= 16'h0000;
      commanded_setpoint    <= 16'h0000;
      temp_command          <= 16'h0000;
    end
    else
    begin
      if (ev_request)
        retry_used_flag <= 1'b1;
      else if (wr_setpoint)
        retry_used_flag <= 1'b0;
      if (ev_stop_clear | ev_request)
        drive_active_flag <= 1'b0;
      else if (wr_drive)
        drive_active_flag <= 1'b1;
      if (ev_request)
        drive_request_flag <= 1'b1;
      else if (wr_ctrl & ahb_req.hwdata[`DOS_CTRL_REQACK])
        drive_request_flag <= 1'b0;
      // limit fault, manual override, or a command over a running one
      if ((wr_ctrl & (ahb_req.hwdata[`DOS_CTRL_LIMIT] |
                      ahb_req.hwdata[`DOS_CTRL_MANUAL])) |
          (wr_setpoint & drive_active_flag))
        shutdown_request_flag <= 1'b1;
      else if (ev_stop_clear)
        shutdown_request_flag <= 1'b0;
      if (ev_fault)
        fault_word[`DOS_FAULT_DRIVE] <= 1'b1;
      else if (wr_fault & ahb_req.hwdata[`DOS_FAULT_DRIVE])
        fault_word[`DOS_FAULT_DRIVE] <= 1'b0;
      if (wr_setpoint)
        commanded_setpoint <= ahb_req.hwdata[15:0];
      if (ev_request)
        temp_command <= commanded_setpoint;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicator bits; limit and mux address bits survive the stop clear

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      ind_reg <= 16'h0000;
    else if (ev_stop_clear)
      ind_reg <= ind_reg & `DOS_IND_MASK;
    else if (wr_ind)
      ind_reg <= ahb_req.hwdata[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops

  assign drive_word    = word_reg;
  assign dac_latch     = latch_reg;
  assign end_of_interrupt_register.wr        = eoi_wr_reg;
  assign end_of_interrupt_register.data      = eoi_data_reg;
  assign brake_release = brake_reg;
  assign timer_stop    = tstop_reg;
  assign indicator     = ind_reg;

endmodule

// file: verif/dos_drive_ctrl_chk.sv
// port assertions of the drive overshoot and shutdown block
`timescale 1ns/1ps

module dos_drive_ctrl_chk
#(
  parameter int unsigned TICK_CYCLES = 40,
  parameter int unsigned PRESCALE    = 20
)
(
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  input wire dos_pkg::dos_ahb_req_t ahb_req,
  input wire dos_pkg::dos_ahb_rsp_t ahb_rsp,
  input wire logic signed [15:0]    pos_error,
  input wire logic                  error_dir,
  input wire logic                  estop_pin,
  input wire logic                  lockout_pin,
  input wire logic [15:0]           drive_word,
  input wire logic                  dac_latch,
  input wire dos_pkg::dos_eoi_t     end_of_interrupt_register,
  input wire logic                  brake_release,
  input wire logic                  timer_stop,
  input wire logic [15:0]           indicator
);
  import dos_pkg::*;
  ////////////////////////////////////////
  // one clock domain, so one default clock and disable
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // slave never stalls and never errors
  a_bus_okay: assert property (ahb_rsp.hreadyout && !ahb_rsp.hresp)
    else $error("bus answer not ready and okay");
  a_stop_word: assert property (timer_stop |-> dac_latch && drive_word == 16'hc000)
    else $error("stop without safe word latch");
  a_stop_once: assert property (timer_stop |=> !timer_stop [*4])
    else $error("timer stop repeated in sequence");
  a_stop_eoi: assert property (timer_stop |=> end_of_interrupt_register.wr && end_of_interrupt_register.data == 16'h0008)
    else $error("stop not followed by eoi code 8");
  a_brake_after: assert property (timer_stop |-> ##2 brake_release)
    else $error("brake not released after stop");
  a_brake_cause: assert property (brake_release |-> $past(timer_stop, 2))
    else $error("brake released without stop");
  // indicator bits 3,5,6 must be cleared once the brake goes
  a_ind_mask: assert property (brake_release |=> (indicator & 16'h0068) == 16'h0000)
    else $error("indicator bits left set");
  a_exit_pair: assert property (
    timer_stop |-> ##3 (end_of_interrupt_register.wr && end_of_interrupt_register.data == 16'h0008) ##1 (end_of_interrupt_register.wr && end_of_interrupt_register.data == 16'h0003))
    else $error("stop exit eoi pair missing");
  a_prio_after: assert property (
    end_of_interrupt_register.wr && end_of_interrupt_register.data == 16'h0003 |-> $past(end_of_interrupt_register.wr) && $past(end_of_interrupt_register.data) == 16'h0008)
    else $error("priority write without eoi 8");
  ////////////////////////////////////////
  // main scenarios reached
  c_stop: cover property (timer_stop);
  c_prio: cover property (end_of_interrupt_register.wr && end_of_interrupt_register.data == 16'h0003);
  c_last_step: cover property (dac_latch && drive_word[11:0] == 12'h004);
endmodule

bind dos_drive_ctrl dos_drive_ctrl_chk #(.TICK_CYCLES(TICK_CYCLES), .PRESCALE(PRESCALE)) chk_inst
(
  .clk_sys, .rstn, .ahb_req, .ahb_rsp, .pos_error, .error_dir, .estop_pin, .lockout_pin,
  .drive_word, .dac_latch, .end_of_interrupt_register, .brake_release, .timer_stop, .indicator
);

// file: verif/dos_drive_model.sv
// far side model: d/a drive latch, brake and servo amplifier
`timescale 1ns/1ps

module dos_drive_model
(
  input wire logic              clk_sys,
  input wire logic              rstn,
  input wire logic [15:0]       drive_word,
  input wire logic              dac_latch,
  input wire logic              brake_release,
  input wire dos_pkg::dos_eoi_t end_of_interrupt_register
);
  import dos_pkg::*;
  logic [15:0] dac_reg  = 16'h0000; // word held by the d/a
  logic [15:0] hist[$];             // latched words that differ from the one before, in order
  int          n_same   = 0;        // relatches of an unchanged word
  int          n_brake  = 0;        // brake releases seen
  int          n_eoi    = 0;        // end-of-interrupt writes seen
  logic        amp_on   = 1'b0;     // servo amplifier enabled
  logic        brake_on = 1'b1;     // brake energized
  ////////////////////////////////////////
  // d/a takes the word only on the latch pulse
  always @(posedge clk_sys)
  begin
    if (rstn && dac_latch)
    begin
      if (drive_word == dac_reg)
        n_same++;
      else
        hist.push_back(drive_word);
      dac_reg = drive_word;
      // c000 keeps relay and brake, inhibits the amplifier
      amp_on  = (drive_word != 16'hc000);
    end
    if (rstn && brake_release)
    begin
      brake_on = 1'b0;
      n_brake++;
    end
    if (rstn && end_of_interrupt_register.wr)
      n_eoi++;
  end
endmodule

// file: verif/dos_drive_ctrl_tb_top.sv
// self-checking testbench of the drive overshoot and shutdown block
`timescale 1ns/1ps

module dos_drive_ctrl_tb_top;
  import dos_pkg::*;
  logic               clk_sys     = 1'b0;
  logic               rstn        = 1'b0;
  dos_ahb_req_t       req         = '{hready: 1'b1, default: '0};
  dos_ahb_rsp_t       rsp;
  logic signed [15:0] pos_error   = 16'sh0064;
  logic               error_dir   = 1'b1;
  logic               estop_pin   = 1'b0;
  logic               lockout_pin = 1'b0;
  logic [15:0]        drive_word;
  logic               dac_latch;
  dos_eoi_t           end_of_interrupt_register;
  logic               brake_release;
  logic               timer_stop;
  logic [15:0]        indicator;
  int                 n_errors    = 0;
  int                 comparisons = 0;
  logic [31:0]        rd_v;       // read data taken at the answer edge
  int                 b;          // model history index at test start
  ////////////////////////////////////////
  always #2 clk_sys = ~clk_sys;
  // short tick and prescaler keep the run brief
  dos_drive_ctrl #(.TICK_CYCLES(40), .PRESCALE(3)) dos_drive_ctrl_inst
  (
    .clk_sys, .rstn, .ahb_req(req), .ahb_rsp(rsp), .pos_error, .error_dir, .estop_pin,
    .lockout_pin, .drive_word, .dac_latch, .end_of_interrupt_register, .brake_release, .timer_stop, .indicator
  );
  dos_drive_model dos_drive_model_inst
  (
    .clk_sys, .rstn, .drive_word, .dac_latch, .brake_release, .end_of_interrupt_register
  );
  ////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // value read just before the edge is what that edge samples
  task wait_rdy;
    int k;
    k = 0;
    @(negedge clk_sys);
    while (rsp.hreadyout !== 1'b1 && k < 99)
    begin
      @(negedge clk_sys);
      k++;
    end
    if (k >= 99)
      n_errors++;
    rd_v = rsp.hrdata;
    @(posedge clk_sys);
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req.hsel   <= 1'b1;
    req.htrans <= 2'b10;
    req.haddr  <= {24'h000000, a};
    req.hwrite <= w;
    req.hsize  <= 3'b010;
    wait_rdy;
    req.htrans <= 2'b00;
    req.hwdata <= d;
    wait_rdy;
    // hsel stays up with htrans idle until the following call drives it high again
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    chk(rd_v, exp);
  endtask
  // wait for the brake release of a stop, then its exit writes
  task wait_stop;
    int k;
    int n;
    n = dos_drive_model_inst.n_brake;
    k = 0;
    while (dos_drive_model_inst.n_brake == n && k < 3000)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 3000)
      n_errors++;
    repeat (4) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////
  task t_reset;
    rd(8'h0c, 32'h00000440);
    rd(8'h08, 32'h00000000);
    rd(8'h3c, 32'h00000000);
    $display("test reset done");
  endtask
  // first overshoot of a positive drive
  task t_overshoot;
    int e;
    wr(8'h00, 32'h00000123);
    b = dos_drive_model_inst.hist.size();
    e = dos_drive_model_inst.n_eoi;
    wr(8'h08, 32'h00001010);
    error_dir <= 1'b0;
    wait_stop;
    chk(dos_drive_model_inst.hist[b], 32'h00001010);
    chk(dos_drive_model_inst.hist[b + 1], 32'h0000100c);
    chk(dos_drive_model_inst.hist[b + 3], 32'h00001004);
    chk(dos_drive_model_inst.hist[$], 32'h0000c000);
    // three ramp ticks of two exit writes each, then the stop's three
    chk(dos_drive_model_inst.n_eoi - e, 32'h00000009);
    chk({31'h0, dos_drive_model_inst.amp_on}, 32'h00000000);
    chk({31'h0, dos_drive_model_inst.brake_on}, 32'h00000000);
    rd(8'h0c, 32'h0000045a);
    rd(8'h14, 32'h00000123);
    $display("test overshoot done");
  endtask
  // second overshoot of a negative drive raises the fault
  task t_fault;
    wr(8'h04, 32'h00000004);
    b = dos_drive_model_inst.hist.size();
    wr(8'h08, 32'h00001ff8);
    error_dir <= 1'b1;
    wait_stop;
    chk(dos_drive_model_inst.hist[b + 1], 32'h00001ffc);
    chk(dos_drive_model_inst.hist[$], 32'h0000c000);
    rd(8'h10, 32'h00000200);
    wr(8'h10, 32'h00000200);
    rd(8'h10, 32'h00000000);
    rd(8'h0c, 32'h00000448);
    wr(8'h00, 32'h00000456);
    rd(8'h0c, 32'h00000440);
    $display("test fault done");
  endtask
  // relatch, then limit fault ramps down
  task t_rampdown;
    int n;
    wr(8'h18, 32'h0000ffff);
    b = dos_drive_model_inst.hist.size();
    n = dos_drive_model_inst.n_same;
    wr(8'h08, 32'h0000200c);
    repeat (100) @(posedge clk_sys);
    chk({31'h0, dos_drive_model_inst.n_same > n}, 32'h00000001);
    wr(8'h04, 32'h00000001);
    wait_stop;
    chk(dos_drive_model_inst.hist[b + 1], 32'h00002008);
    chk(dos_drive_model_inst.hist[b + 2], 32'h00002004);
    chk(dos_drive_model_inst.hist[$], 32'h0000c000);
    rd(8'h18, 32'h0000ff97);
    rd(8'h0c, 32'h00000450);
    $display("test ramp-down done");
  endtask
  // estop and lockout stop at the next tick, small error converges,
  // manual override and a command over a running one ramp down
  task t_direct;
    for (int i = 0; i < 5; i++)
    begin
      pos_error <= (i == 2) ? 16'sh0002 : 16'sh0064;
      wr(8'h08, 32'h00003010);
      repeat (10) @(posedge clk_sys);
      estop_pin   <= (i == 0);
      lockout_pin <= (i == 1);
      if (i == 3)
        wr(8'h04, 32'h00000002);
      if (i == 4)
        wr(8'h00, 32'h00000123);
      wait_stop;
      chk(dos_drive_model_inst.hist[$], 32'h0000c000);
      if (i < 2)
        chk(dos_drive_model_inst.hist[$ - 1], 32'h00003010);
      else
        chk(dos_drive_model_inst.hist[$ - 1], 32'h00003000);
      estop_pin   <= 1'b0;
      lockout_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    $display("test direct stop done");
  endtask
  ////////////////////////////////////////
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // reset, one spare edge, then the scenarios
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_overshoot;
    t_fault;
    t_rampdown;
    t_direct;
    close_out;
  end
  // the scenarios need about 2500 cycles; the limit leaves ample margin
  initial
  begin
    #100000;
    n_errors++;
    close_out;
  end
endmodule
